// ### src/exec_state_pkg.sv
// Purpose: shared constants and types for the execution-state unit
// Assumes: one 20 MHz core clock, register port with one-cycle read data
// Notes: field layout follows the combined status word bit numbering
package exec_state_pkg;

  localparam int unsigned ADDR_W = 4;
  localparam logic [ADDR_W-1:0] OFS_EXEC_STATUS = 4'h0;
  localparam logic [ADDR_W-1:0] OFS_INT_STATUS = 4'h4;
  localparam logic [ADDR_W-1:0] OFS_INT_MASK = 4'h8;
  localparam logic [ADDR_W-1:0] OFS_CONTROL = 4'hC;

  // status word field positions
  localparam int unsigned POS_EXEC_HI = 25;
  localparam int unsigned POS_ISA = 24;
  localparam int unsigned POS_EXEC_LO = 10;
  localparam int unsigned POS_RESUME_REG = 12;

  localparam logic ISA_RESET = 1'h1;
  localparam logic [7:0] EXEC_RESET = 8'h00;
  localparam logic [31:0] WORD_ZERO = 32'h0000_0000;

  // interrupt status bit positions
  localparam int unsigned NUM_EVENTS = 4;
  localparam int unsigned EV_FAULT = 0;
  localparam int unsigned EV_LOCKUP = 1;
  localparam int unsigned EV_SUSPEND = 2;
  localparam int unsigned EV_ISA_CLEAR = 3;
  localparam logic [NUM_EVENTS-1:0] EV_RESET = 4'h0;

  // control register bit positions
  localparam int unsigned CTL_LOCKUP_SEL = 0;

  typedef enum logic [1:0] {
    FIELD_IDLE = 2'b00,
    FIELD_RESUME = 2'b01,
    FIELD_BLOCK = 2'b10
  } field_mode_t;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [31:0] wdata;
    logic write;
    logic read;
  } reg_req_t;

  typedef struct packed {
    logic valid;
    logic [31:0] word;
  } stacked_word_t;

endpackage

// ### src/block_state_step.sv
// Purpose: advance of the conditional block state by one instruction
// Assumes: state[7:4] is the current condition, state[3:0] the mask
// Notes: purely combinational, no state of its own
module block_state_step
  import exec_state_pkg::*;
(
  input wire logic [7:0] state,
  output logic [7:0] stepped,
  output logic last
);

  always_comb begin
    last = (state[2:0] == 3'h0);
    if (last) begin
      stepped = 8'h00;
    end else begin
      stepped = {state[7:5], state[3:0], 1'b0};
    end
  end

endmodule

// ### src/exec_state_unit.sv
// Purpose: execution-state bits of the core's program status word
// Assumes: all event inputs come from core logic on core_clk
// Notes: register port reads return data in the cycle after the strobe
//
// Operation
// - bits 26:25 and 15:10 form one field
// - resume state holds bits 26:25 at zero
// - resume state holds bits 11:10 at zero
// - suspended transfer records next register number
// - restart transfer at the recorded register
// - block covers up to four conditional instructions
// - instruction-set flag bit 24, reset one
// - flag updated by branches, return, vector
// - clear flag on execute raises fault or lockup
// - reserved bits 23:16 and 9:6 read zero
// - reset vector bit zero loads the flag
// - move-from read returns zero, writes ignored
module exec_state_unit
  import exec_state_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst_b,
  // register port
  input wire logic [ADDR_W-1:0] regAddr,
  input wire logic [31:0] regWdata,
  input wire logic regWrite,
  input wire logic regRead,
  output logic [31:0] regRdata,
  output logic irq,
  // core events
  input wire logic vectorFetch,
  input wire logic vectorBit0,
  input wire logic branchIndirect,
  input wire logic branchTargetBit0,
  input wire logic excReturn,
  input wire logic [31:0] stackedWord,
  input wire logic transferSuspend,
  input wire logic [3:0] transferNextReg,
  input wire logic transferResumeAck,
  input wire logic transferDone,
  input wire logic blockStart,
  input wire logic blockStartNarrow,
  input wire logic [7:0] blockStartState,
  input wire logic blockStep,
  input wire logic instrIssue,
  input wire logic moveFromSpecial,
  input wire logic moveToSpecial,
  input wire logic [31:0] moveToData,
  // status views
  output logic [31:0] execStatus,
  output logic [31:0] moveFromData,
  output logic resumePending,
  output logic [3:0] resumeReg,
  output logic blockActive,
  output logic [3:0] blockCond,
  output logic faultRaise,
  output logic lockup
);

  typedef struct packed {
    // field and flag
    field_mode_t mode;
    logic [7:0] field;
    logic isa;
    logic resumeIssued;
    // event status and control
    logic [NUM_EVENTS-1:0] intStatus;
    logic [NUM_EVENTS-1:0] intMask;
    logic lockupSel;
    logic lockup;
    logic faultRaise;
    // registered output images
    logic irq;
    logic [31:0] rdata;
    logic [31:0] moveFrom;
    logic [31:0] word;
    logic resumePending;
    logic [3:0] resumeReg;
    logic blockActive;
    logic [3:0] blockCond;
  } state_t;

  localparam state_t STATE_RESET = '{
    mode: FIELD_IDLE,
    field: EXEC_RESET,
    isa: ISA_RESET,
    resumeIssued: 1'b0,
    intStatus: EV_RESET,
    intMask: EV_RESET,
    lockupSel: 1'b0,
    lockup: 1'b0,
    faultRaise: 1'b0,
    irq: 1'b0,
    rdata: WORD_ZERO,
    moveFrom: WORD_ZERO,
    word: WORD_ZERO | (32'(ISA_RESET) << POS_ISA),
    resumePending: 1'b0,
    resumeReg: 4'h0,
    blockActive: 1'b0,
    blockCond: 4'h0
  };

  state_t cur;
  state_t next_cur;
  reg_req_t req;
  logic [7:0] stepped;
  logic stepLast;
  logic [NUM_EVENTS-1:0] events;
  logic executeBlocked;
  logic [7:0] stackedField;
  stacked_word_t restore;
  field_mode_t stackedMode;
  logic blockStartOk;
  logic stepAccept;
  logic resumeFinish;
  logic [NUM_EVENTS-1:0] statusClear;

  assign req = '{addr: regAddr, wdata: regWdata, write: regWrite,
                 read: regRead};

  // conditional block advance
  block_state_step stepper (
    .state(cur.field),
    .stepped(stepped),
    .last(stepLast)
  );

  // sorts a restored word into idle, resume or block state
  function automatic field_mode_t classify(input logic [31:0] sw);
    field_mode_t m;
    if ({sw[15:10], sw[26:25]} == EXEC_RESET) begin
      m = FIELD_IDLE;
    end else if (sw[26:25] == 2'h0 && sw[11:10] == 2'h0) begin
      m = FIELD_RESUME;
    end else begin
      m = FIELD_BLOCK;
    end
    return m;
  endfunction

  // restored status word with its strobe
  assign restore = '{valid: excReturn, word: stackedWord};

  // field image of the stacked word: bits 15:10 above bits 26:25
  assign stackedField = {restore.word[15:10], restore.word[26:25]};
  assign stackedMode = classify(restore.word);

  // instruction issue with the flag clear outside lockup never executes
  assign executeBlocked = instrIssue && !cur.isa && !cur.lockup;

  // block step and resume completion
  assign stepAccept = blockStep && !executeBlocked;
  assign resumeFinish = transferDone && cur.resumeIssued;

  // only a narrow start with a live mask opens a block
  assign blockStartOk = blockStart && blockStartNarrow &&
                        blockStartState[3:0] != 4'h0;

  // per-bit write-one-to-clear strobes of the event status
  for (genvar e = 0; e < NUM_EVENTS; e++) begin : g_clear
    assign statusClear[e] = req.write && req.addr == OFS_INT_STATUS &&
                            req.wdata[e];
  end

  // builds the status word view of the field and flag
  function automatic logic [31:0] pack_word(input field_mode_t mode,
                                            input logic [7:0] field,
                                            input logic isa);
    logic [31:0] w;
    w = WORD_ZERO;
    w[POS_ISA] = isa;
    if (mode == FIELD_RESUME) begin
      w[POS_RESUME_REG +: 4] = field[7:4];
    end else if (mode == FIELD_BLOCK) begin
      w[POS_EXEC_LO +: 6] = field[7:2];
      w[POS_EXEC_HI +: 2] = field[1:0];
    end
    return w;
  endfunction

  always_comb begin
    next_cur = cur;
    events = EV_RESET;
    next_cur.faultRaise = 1'b0;

    // instruction-set flag sources, vector fetch taking priority
    if (vectorFetch) begin
      next_cur.isa = vectorBit0;
    end else if (restore.valid) begin
      next_cur.isa = restore.word[POS_ISA];
    end else if (branchIndirect) begin
      next_cur.isa = branchTargetBit0;
    end
    if (cur.isa && !next_cur.isa) begin
      events[EV_ISA_CLEAR] = 1'b1;
    end

    // execution-state field
    if (restore.valid) begin
      next_cur.mode = stackedMode;
      unique case (stackedMode)
        FIELD_RESUME: begin
          next_cur.field = {restore.word[15:12], 4'h0};
        end
        FIELD_BLOCK: begin
          next_cur.field = stackedField;
        end
        default: begin
          next_cur.field = EXEC_RESET;
        end
      endcase
      next_cur.resumeIssued = 1'b0;
    end else if (transferSuspend) begin
      next_cur.mode = FIELD_RESUME;
      next_cur.field = {transferNextReg, 4'h0};
      next_cur.resumeIssued = 1'b0;
      events[EV_SUSPEND] = 1'b1;
    end else if (blockStartOk) begin
      next_cur.mode = FIELD_BLOCK;
      next_cur.field = blockStartState;
    end else begin
      unique case (cur.mode)
        FIELD_IDLE: begin
          next_cur.field = EXEC_RESET;
        end
        FIELD_RESUME: begin
          if (transferResumeAck) begin
            next_cur.resumeIssued = 1'b1;
          end
          if (resumeFinish) begin
            next_cur.mode = FIELD_IDLE;
            next_cur.field = EXEC_RESET;
            next_cur.resumeIssued = 1'b0;
          end
        end
        FIELD_BLOCK: begin
          if (stepAccept) begin
            next_cur.field = stepped;
            if (stepLast) begin
              next_cur.mode = FIELD_IDLE;
            end
          end
        end
        default: begin
          next_cur.mode = FIELD_IDLE;
          next_cur.field = EXEC_RESET;
        end
      endcase
    end

    // fault or lockup on blocked execution
    if (executeBlocked) begin
      if (cur.lockupSel) begin
        next_cur.lockup = 1'b1;
        events[EV_LOCKUP] = 1'b1;
      end else begin
        next_cur.faultRaise = 1'b1;
        events[EV_FAULT] = 1'b1;
      end
    end

    // register port writes; status is write-one-to-clear
    if (req.write) begin
      unique case (req.addr)
        OFS_INT_STATUS: begin
          next_cur.intStatus = cur.intStatus & ~statusClear;
        end
        OFS_INT_MASK: begin
          next_cur.intMask = req.wdata[NUM_EVENTS-1:0];
        end
        OFS_CONTROL: begin
          next_cur.lockupSel = req.wdata[CTL_LOCKUP_SEL];
        end
        default: begin
          next_cur.intMask = cur.intMask;
        end
      endcase
    end
    // a new event wins over a clear in the same cycle
    next_cur.intStatus = next_cur.intStatus | events;
    next_cur.irq = |(next_cur.intStatus & next_cur.intMask);

    // register port reads, data valid one cycle only
    next_cur.rdata = WORD_ZERO;
    if (req.read) begin
      unique case (req.addr)
        OFS_EXEC_STATUS: begin
          next_cur.rdata = cur.word;
        end
        OFS_INT_STATUS: begin
          next_cur.rdata[NUM_EVENTS-1:0] = cur.intStatus;
        end
        OFS_INT_MASK: begin
          next_cur.rdata[NUM_EVENTS-1:0] = cur.intMask;
        end
        OFS_CONTROL: begin
          next_cur.rdata[CTL_LOCKUP_SEL] = cur.lockupSel;
        end
        default: begin
          next_cur.rdata = WORD_ZERO;
        end
      endcase
    end

    // software access by special-register move sees nothing
    next_cur.moveFrom = WORD_ZERO;
    if (moveFromSpecial) begin
      next_cur.moveFrom = WORD_ZERO;
    end
    if (moveToSpecial && moveToData != WORD_ZERO) begin
      next_cur.moveFrom = WORD_ZERO;
    end

    // output images
    next_cur.word = pack_word(next_cur.mode, next_cur.field, next_cur.isa);
    next_cur.resumePending = (next_cur.mode == FIELD_RESUME) &&
                             !next_cur.resumeIssued;
    next_cur.resumeReg = (next_cur.mode == FIELD_RESUME) ?
                         next_cur.field[7:4] : 4'h0;
    next_cur.blockActive = (next_cur.mode == FIELD_BLOCK);
    next_cur.blockCond = (next_cur.mode == FIELD_BLOCK) ?
                         next_cur.field[7:4] : 4'h0;
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      cur <= STATE_RESET;
    end else begin
      cur <= next_cur;
    end
  end

  assign regRdata = cur.rdata;
  assign irq = cur.irq;
  assign execStatus = cur.word;
  assign moveFromData = cur.moveFrom;
  assign resumePending = cur.resumePending;
  assign resumeReg = cur.resumeReg;
  assign blockActive = cur.blockActive;
  assign blockCond = cur.blockCond;
  assign faultRaise = cur.faultRaise;
  assign lockup = cur.lockup;

endmodule

// ### sim/exec_state_asserts.sv
// Purpose: port checks of the execution-state unit
// Assumes: one core_clk domain, rst_b active low
// Notes: bound to the unit at the foot of this file
module exec_state_asserts
  import exec_state_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic [ADDR_W-1:0] regAddr,
  input wire logic regRead,
  input wire logic [31:0] regRdata,
  input wire logic vectorFetch,
  input wire logic vectorBit0,
  input wire logic excReturn,
  input wire logic transferSuspend,
  input wire logic [3:0] transferNextReg,
  input wire logic instrIssue,
  input wire logic [31:0] execStatus,
  input wire logic [31:0] moveFromData,
  input wire logic resumePending,
  input wire logic [3:0] resumeReg,
  input wire logic blockActive,
  input wire logic faultRaise,
  input wire logic lockup
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_b);
  AST_RSVD_ZERO:
  assert property ({execStatus[31:27], execStatus[23:16],
    execStatus[9:0]} == 23'h0) else $error("reserved bits set");
  AST_MOVE_FROM_ZERO:
  assert property (moveFromData == WORD_ZERO) else $error("move-from");
  AST_STATUS_READ:
  assert property (regRead && regAddr == OFS_EXEC_STATUS |=>
    regRdata == $past(execStatus)) else $error("status read");
  AST_SUSPEND_REG:
  assert property (transferSuspend && !excReturn |=> resumePending &&
    resumeReg == $past(transferNextReg) &&
    execStatus[15:12] == $past(transferNextReg)) else $error("suspend");
  AST_RESUME_ZEROS:
  assert property (resumePending |-> execStatus[26:25] == 2'h0 &&
    execStatus[11:10] == 2'h0) else $error("resume zeros");
  AST_BLOCK_MASK:
  assert property (blockActive |->
    {execStatus[11:10], execStatus[26:25]} != 4'h0) else $error("mask");
  AST_VECTOR_FLAG:
  assert property (vectorFetch |=>
    execStatus[POS_ISA] == $past(vectorBit0)) else $error("vector");
  AST_FAULT:
  assert property (instrIssue && !execStatus[POS_ISA] && !lockup |=>
    faultRaise ^ lockup) else $error("no fault");
endmodule

bind exec_state_unit exec_state_asserts i_chk (
  .core_clk(core_clk),
  .rst_b(rst_b),
  .regAddr(regAddr),
  .regRead(regRead),
  .regRdata(regRdata),
  .vectorFetch(vectorFetch),
  .vectorBit0(vectorBit0),
  .excReturn(excReturn),
  .transferSuspend(transferSuspend),
  .transferNextReg(transferNextReg),
  .instrIssue(instrIssue),
  .execStatus(execStatus),
  .moveFromData(moveFromData),
  .resumePending(resumePending),
  .resumeReg(resumeReg),
  .blockActive(blockActive),
  .faultRaise(faultRaise),
  .lockup(lockup)
);

// ### sim/tb.sv
// Purpose: self-checking bench of the execution-state unit
// Assumes: 20 MHz core_clk, fixed one-cycle answers
// Notes: inputs change by non-blocking assignment after rising edges
module tb
  import exec_state_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic core_clk, rst_b, regWrite, regRead, vectorFetch, vectorBit0;
  logic branchIndirect, branchTargetBit0, excReturn, transferSuspend;
  logic transferResumeAck, transferDone, blockStart, blockStartNarrow;
  logic blockStep, instrIssue, moveFromSpecial, moveToSpecial;
  logic [ADDR_W-1:0] regAddr;
  logic [31:0] regWdata, stackedWord, moveToData, regRdata;
  logic [31:0] execStatus, moveFromData;
  logic [3:0] transferNextReg, resumeReg, blockCond;
  logic [7:0] blockStartState;
  logic irq, resumePending, blockActive, faultRaise, lockup;
  int numErrors, nCompared;
  exec_state_unit i_dut (
    .core_clk(core_clk),
    .rst_b(rst_b),
    .regAddr(regAddr),
    .regWdata(regWdata),
    .regWrite(regWrite),
    .regRead(regRead),
    .regRdata(regRdata),
    .irq(irq),
    .vectorFetch(vectorFetch),
    .vectorBit0(vectorBit0),
    .branchIndirect(branchIndirect),
    .branchTargetBit0(branchTargetBit0),
    .excReturn(excReturn),
    .stackedWord(stackedWord),
    .transferSuspend(transferSuspend),
    .transferNextReg(transferNextReg),
    .transferResumeAck(transferResumeAck),
    .transferDone(transferDone),
    .blockStart(blockStart),
    .blockStartNarrow(blockStartNarrow),
    .blockStartState(blockStartState),
    .blockStep(blockStep),
    .instrIssue(instrIssue),
    .moveFromSpecial(moveFromSpecial),
    .moveToSpecial(moveToSpecial),
    .moveToData(moveToData),
    .execStatus(execStatus),
    .moveFromData(moveFromData),
    .resumePending(resumePending),
    .resumeReg(resumeReg),
    .blockActive(blockActive),
    .blockCond(blockCond),
    .faultRaise(faultRaise),
    .lockup(lockup)
  );
  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end
  task automatic cyc;
    @(posedge core_clk);
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    nCompared++;
    if (got !== exp) begin
      numErrors++;
      $display("CHECK FAILED at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic tally_and_finish;
    $display("compared %0d errors %0d", nCompared, numErrors);
    if (numErrors == 0 && nCompared > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    cyc;
    regAddr <= a;
    regWdata <= d;
    regWrite <= 1'b1;
    cyc;
    regWrite <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [31:0] e);
    cyc;
    regAddr <= a;
    regRead <= 1'b1;
    cyc;
    regRead <= 1'b0;
    #1 chk(regRdata, e);
  endtask
  task automatic ret(input logic [31:0] w);
    cyc;
    stackedWord <= w;
    excReturn <= 1'b1;
    cyc;
    excReturn <= 1'b0;
    #1;
  endtask
  task automatic t_regs;
    rd(OFS_EXEC_STATUS, 32'h0100_0000);
    wr(OFS_EXEC_STATUS, 32'hFFFF_FFFF);
    rd(OFS_EXEC_STATUS, 32'h0100_0000);
    rd(4'h2, WORD_ZERO);
    cyc;
    moveToData <= 32'hFFFF_FFFF;
    {moveToSpecial, moveFromSpecial} <= 2'h3;
    cyc;
    {moveToSpecial, moveFromSpecial} <= 2'h0;
    #1 chk(moveFromData, WORD_ZERO);
    chk(execStatus, 32'h0100_0000);
  endtask
  task automatic t_resume;
    wr(OFS_INT_MASK, 32'h4);
    cyc;
    transferSuspend <= 1'b1;
    transferNextReg <= 4'hF;
    cyc;
    transferSuspend <= 1'b0;
    #1 chk(execStatus, 32'h0100_F000);
    cyc;
    #1 chk(irq, 1'b1);
    cyc;
    transferResumeAck <= 1'b1;
    cyc;
    transferResumeAck <= 1'b0;
    #1 chk({resumePending, resumeReg}, 5'h0F);
    cyc;
    transferDone <= 1'b1;
    cyc;
    transferDone <= 1'b0;
    #1 chk(execStatus, 32'h0100_0000);
    wr(OFS_INT_STATUS, 32'h4);
    cyc;
    #1 chk(irq, 1'b0);
  endtask
  task automatic t_block;
    cyc;
    blockStart <= 1'b1;
    blockStartState <= 8'h11;
    cyc;
    blockStart <= 1'b0;
    #1 chk(blockActive, 1'b0);
    cyc;
    {blockStart, blockStartNarrow} <= 2'h3;
    cyc;
    blockStart <= 1'b0;
    #1 chk(execStatus, 32'h0300_1000);
    chk(blockCond, 4'h1);
    for (int i = 0; i < 4; i++) begin
      cyc;
      blockStep <= 1'b1;
      cyc;
      blockStep <= 1'b0;
      #1 chk(blockActive, i < 3);
    end
    chk(execStatus, 32'h0100_0000);
  endtask
  task automatic t_flag;
    cyc;
    branchIndirect <= 1'b1;
    cyc;
    branchIndirect <= 1'b0;
    #1 chk(execStatus, WORD_ZERO);
    cyc;
    instrIssue <= 1'b1;
    cyc;
    instrIssue <= 1'b0;
    #1 chk({faultRaise, lockup}, 2'h2);
    rd(OFS_INT_STATUS, 32'h9);
    chk(irq, 1'b0);
    wr(OFS_INT_STATUS, 32'hF);
    cyc;
    {vectorFetch, vectorBit0} <= 2'h3;
    cyc;
    vectorFetch <= 1'b0;
    #1 chk(execStatus, 32'h0100_0000);
    ret(WORD_ZERO);
    chk(execStatus, WORD_ZERO);
    wr(OFS_CONTROL, 32'h1);
    cyc;
    instrIssue <= 1'b1;
    cyc;
    instrIssue <= 1'b0;
    #1 chk({faultRaise, lockup}, 2'h1);
  endtask
  task automatic t_restore;
    ret(32'h01FF_33C0);
    chk(execStatus, 32'h0100_3000);
    chk({resumePending, resumeReg}, 5'h13);
    ret(32'h0300_1000);
    chk(execStatus, 32'h0300_1000);
    chk(blockCond, 4'h1);
    ret(32'h0100_0000);
    chk(execStatus, 32'h0100_0000);
  endtask
  task automatic t_reset;
    cyc;
    rst_b <= 1'b0;
    cyc;
    #1 chk(execStatus, 32'h0100_0000);
    chk({faultRaise, lockup, blockActive, resumePending}, 4'h0);
    cyc;
    rst_b <= 1'b1;
    rd(OFS_EXEC_STATUS, 32'h0100_0000);
  endtask
  initial begin
    {rst_b, regWrite, regRead, vectorFetch, vectorBit0, branchIndirect,
      branchTargetBit0, excReturn, transferSuspend, transferResumeAck,
      transferDone, blockStart, blockStartNarrow, blockStep, instrIssue,
      moveFromSpecial, moveToSpecial} = '0;
    {regAddr, regWdata, stackedWord, moveToData} = '0;
    {transferNextReg, blockStartState} = '0;
    repeat (16) cyc;
    chk(execStatus, 32'h0100_0000);
    rst_b <= 1'b1;
    t_regs;
    t_resume;
    t_block;
    t_restore;
    t_flag;
    t_reset;
    tally_and_finish;
  end
  initial begin
    repeat (4000) cyc;
    numErrors++;
    tally_and_finish;
  end
endmodule
